// >>> core/standby_pkg.sv
// shared constants, register map and carrier types of the deep standby controller
// What this block does
// - five-bit wait code 05..0F picks 64 to 524288 peripheral clocks; others reserved
// - sleep with both select bits and no wake pending enters deep standby after one cycle of software standby
// - wake during entry leaves standby, interrupt handling after five-bit wait
// - deep standby halts and unpowers CPU, peripherals except USB, RAM block 4, oscillator
// - all power-cut bits clear keep RAM 3..0 and USB powered; all set cut them
// - port pins hold their software standby state through deep standby
// - deep standby ends when NMI, pin or USB wake flag becomes one
// - pin wake flags set on selected edge; interrupt pins also need enable
// - voltage monitor interrupt and USB interrupt set their own wake flags
// - deep wake restarts power and oscillator under internal reset for six-bit wait
// - exit by wake flag sets deep reset source flag in reset status
// - reset pin low restarts everything; held low until stable; rise starts reset handling
// - standby pin low in deep standby goes straight to hardware standby
// - bus pins follow CPU operation after deep standby exit, not retained
// - keep bit clear: other pins reinitialised by the deep internal reset
// - keep bit set: pins stay held until software clears keep bit
// - keep bit survives the internal reset that ends deep standby
// - bus clock output may glitch one cycle when retention ends
// - voltage monitor reset restarts all but this block's registers and flags, releases after recovery plus settling time
// - sleep with standby bit and deep bit clear stops CPU, peripherals, oscillator
package standby_pkg;

  // register indices on the plain register port
  localparam logic [2:0] ADDR_STANDBY_CTRL = 3'h0;
  localparam logic [2:0] ADDR_DEEP_CTRL = 3'h1;
  localparam logic [2:0] ADDR_WAKE_ENABLE = 3'h2;
  localparam logic [2:0] ADDR_WAKE_EDGE = 3'h3;
  localparam logic [2:0] ADDR_WAKE_FLAG = 3'h4;
  localparam logic [2:0] ADDR_DEEP_WAIT = 3'h5;
  localparam logic [2:0] ADDR_RESET_STATUS = 3'h6;
  localparam logic [2:0] ADDR_STATE = 3'h7;

  // field positions
  localparam int STANDBY_SEL_BIT = 7;
  localparam int CLOCK_STOP_BIT = 6;
  localparam int DEEP_SEL_BIT = 7;
  localparam int PORT_KEEP_BIT = 6;
  localparam int FLAG_NMI_BIT = 4;
  localparam int FLAG_VMON_BIT = 5;
  localparam int FLAG_USB_BIT = 6;
  localparam int DEEP_RESET_SRC_BIT = 7;

  // reset values
  localparam logic [4:0] STANDBY_WAIT_RESET = 5'h0F;
  localparam logic [5:0] DEEP_WAIT_RESET = 6'h3F;
  localparam logic [2:0] RAM_CUT_ALL = 3'h7;

  // standby wait table, codes 05..0F, entry 0 is code 05
  localparam logic [4:0] STANDBY_CODE_FIRST = 5'h05;
  localparam logic [4:0] STANDBY_CODE_LAST = 5'h0F;
  localparam int WAIT_W = 20;
  localparam logic [10:0][WAIT_W-1:0] STANDBY_WAIT_CYCLES = {
    20'h80000, 20'h40000, 20'h20000, 20'h10000, 20'h08000, 20'h04000,
    20'h01000, 20'h00800, 20'h00400, 20'h00200, 20'h00040};
  // six-bit deep wait code is shifted left by this many bits, 256 input clocks per step
  localparam int DEEP_WAIT_SHIFT = 8;

  typedef enum logic [2:0] {
    ST_RUN, ST_SW_STANDBY_PIN, ST_SW_WAKE, ST_DEEP, ST_DEEP_WAKE, ST_PIN_RESET, ST_VMON_RESET, ST_HW_STANDBY_PIN
  } state_e;

  typedef struct packed {
    logic cpu_stop;
    logic periph_stop;
    logic osc_stop;
    logic core_power_off;
    logic ram4_power_off;
    logic ram_usb_power_off;
    logic hw_standby;
  } power_ctrl_s;

  typedef struct packed {
    logic port_hold;
    logic bus_hold;
    logic clock_out_run;
    logic clock_out_high;
  } port_ctrl_s;

endpackage : standby_pkg

// >>> core/wake_sync_edge.sv
// two-stage synchroniser with per-bit selectable edge detection
`timescale 1ns/1ps
module wake_sync_edge #(
  parameter int W = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [W-1:0] pin_in,
  input wire logic [W-1:0] rise_sel,
  output logic [W-1:0] level,
  output logic [W-1:0] edge_seen
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] prev_q;

  // first stage feeds only the second stage
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= RESET_VAL;
      sync_q <= RESET_VAL;
      prev_q <= RESET_VAL;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // edge polarity chosen bit by bit
  assign level = sync_q;
  assign edge_seen = (rise_sel & sync_q & ~prev_q) | (~rise_sel & ~sync_q & prev_q);

endmodule : wake_sync_edge

// >>> core/deep_standby_controller.sv
// power-down sequencer for software standby and deep software standby
//
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
module deep_standby_controller #(
  parameter int unsigned wait_shift = 0
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic sleep_req,
  input wire logic nmi_pin,
  input wire logic [3:0] wake_interrupt_pins,
  input wire logic reset_pin_b,
  input wire logic standby_pin_b,
  input wire logic voltage_monitor_irq,
  input wire logic voltage_monitor_reset,
  input wire logic usb_suspend_resume_irq,
  output standby_pkg::power_ctrl_s power,
  output standby_pkg::port_ctrl_s ports,
  output logic internal_reset,
  output logic irq_handling_start,
  output logic reset_exception_start
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  standby_pkg::state_e state_q, state_d;
  logic standby_sel_q, clock_stop_q, deep_sel_q, port_keep_q;
  logic [4:0] standby_wait_q, wake_edge_q;
  logic [2:0] ram_cut_q;
  logic [3:0] wake_enable_q;
  logic [5:0] deep_wait_q;
  logic [6:0] flags_q, flags_read_q;
  logic deep_rst_src_q, deep_rst_read_q, keep_hold_q;
  logic [standby_pkg::WAIT_W-1:0] wait_q;
  logic [7:0] rdata_q;
  logic irq_start_q, rst_exc_q;
  standby_pkg::power_ctrl_s power_q;
  standby_pkg::port_ctrl_s ports_q;
  logic [4:0] pin_level, pin_edge, ctl_level, ctl_edge;
  logic [6:0] flag_set, flag_clr;
  logic deep_cancel, sys_clear, wait_done;
  logic [standby_pkg::WAIT_W-1:0] standby_load, deep_load;
  logic [3:0] table_idx;
  logic do_write, state_hold, state_deep_like;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and wake event detection

  // wake pins: bits 3..0 interrupt pins, bit 4 NMI, polarity from edge register
  wake_sync_edge #(
    .W(5),
    .RESET_VAL(5'h00)
  ) u_pin_sync (
    .clock(clock),
    .rst_b(rst_b),
    .pin_in({nmi_pin, wake_interrupt_pins}),
    .rise_sel(wake_edge_q),
    .level(pin_level),
    .edge_seen(pin_edge)
  );

  // control pins and internal requests: reset, standby, vmon reset, vmon irq, usb irq
  wake_sync_edge #(
    .W(5),
    .RESET_VAL(5'h03)
  ) u_ctl_sync (
    .clock(clock),
    .rst_b(rst_b),
    .pin_in({usb_suspend_resume_irq, voltage_monitor_irq, voltage_monitor_reset, standby_pin_b, reset_pin_b}),
    .rise_sel(5'h1F),
    .level(ctl_level),
    .edge_seen(ctl_edge)
  );

  // events that set wake flags; interrupt pins need their enable
  always_comb begin
    flag_set = 7'h00;
    flag_set[3:0] = pin_edge[3:0] & wake_enable_q;
    flag_set[standby_pkg::FLAG_NMI_BIT] = pin_edge[4];
    flag_set[standby_pkg::FLAG_VMON_BIT] = ctl_edge[3];
    flag_set[standby_pkg::FLAG_USB_BIT] = ctl_edge[4];
  end

  // cancel deep standby on pin, NMI or USB flag; voltage monitor flag does not
  assign deep_cancel = |flags_q[3:0] | flags_q[standby_pkg::FLAG_NMI_BIT]
                       | flags_q[standby_pkg::FLAG_USB_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // wait time loads

  // reserved codes fall back to the longest wait, the safe side for settling
  always_comb begin
    if (standby_wait_q < standby_pkg::STANDBY_CODE_FIRST || standby_wait_q > standby_pkg::STANDBY_CODE_LAST) begin
      table_idx = 4'hA;
    end else begin
      table_idx = 4'(standby_wait_q - standby_pkg::STANDBY_CODE_FIRST);
    end
  end

  assign standby_load = standby_pkg::STANDBY_WAIT_CYCLES[table_idx] >> wait_shift;
  // code zero is reserved; it is treated as one step so the wait never vanishes
  assign deep_load = (deep_wait_q == 6'h00) ? (20'h00001 << standby_pkg::DEEP_WAIT_SHIFT)
                   : ({14'h0000, deep_wait_q} << standby_pkg::DEEP_WAIT_SHIFT);
  assign wait_done = (wait_q <= 20'h00001);

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  assign sys_clear = (state_q == standby_pkg::ST_PIN_RESET) || (state_q == standby_pkg::ST_HW_STANDBY_PIN);

  // standby pin wins over the reset pin, which wins over voltage monitor reset
  always_comb begin
    state_d = state_q;
    if (!ctl_level[1]) begin
      state_d = standby_pkg::ST_HW_STANDBY_PIN;
    end else if (state_q == standby_pkg::ST_HW_STANDBY_PIN) begin
      if (!ctl_level[0]) begin
        state_d = standby_pkg::ST_PIN_RESET;
      end
    end else if (!ctl_level[0]) begin
      state_d = standby_pkg::ST_PIN_RESET;
    end else if (ctl_level[2]) begin
      state_d = standby_pkg::ST_VMON_RESET;
    end else begin
      case (state_q)
        standby_pkg::ST_RUN: begin
          if (sleep_req && standby_sel_q) begin
            state_d = standby_pkg::ST_SW_STANDBY_PIN;
          end
        end
        standby_pkg::ST_SW_STANDBY_PIN: begin
          if (|flag_set) begin
            state_d = standby_pkg::ST_SW_WAKE;
          end else if (deep_sel_q) begin
            state_d = standby_pkg::ST_DEEP;
          end
        end
        standby_pkg::ST_SW_WAKE: begin
          if (wait_done) begin
            state_d = standby_pkg::ST_RUN;
          end
        end
        standby_pkg::ST_DEEP: begin
          if (deep_cancel) begin
            state_d = standby_pkg::ST_DEEP_WAKE;
          end
        end
        standby_pkg::ST_DEEP_WAKE, standby_pkg::ST_VMON_RESET: begin
          if (wait_done) begin
            state_d = standby_pkg::ST_RUN;
          end
        end
        standby_pkg::ST_PIN_RESET: begin
          state_d = standby_pkg::ST_RUN;
        end
        default: begin
          state_d = standby_pkg::ST_RUN;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= standby_pkg::ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // wait counter: loaded on entry, counts down, restarts while vmon reset stays high
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wait_q <= '0;
    end else if (state_d == standby_pkg::ST_SW_WAKE && state_q != standby_pkg::ST_SW_WAKE) begin
      wait_q <= standby_load;
    end else if (state_d == standby_pkg::ST_DEEP_WAKE && state_q != standby_pkg::ST_DEEP_WAKE) begin
      wait_q <= deep_load;
    end else if (state_d == standby_pkg::ST_VMON_RESET && ctl_level[2]) begin
      wait_q <= deep_load;
    end else if (!wait_done) begin
      wait_q <= wait_q - 20'h00001;
    end
  end

  // one-cycle starts; reset handling begins only in the first cycle after the internal reset drops
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      irq_start_q <= 1'b0;
      rst_exc_q <= 1'b0;
    end else begin
      irq_start_q <= (state_q == standby_pkg::ST_SW_WAKE) && (state_d == standby_pkg::ST_RUN);
      rst_exc_q <= internal_reset && (state_q == standby_pkg::ST_RUN);
    end
  end

  // retention after exit lasts until software clears the keep bit
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      keep_hold_q <= 1'b0;
    end else if (sys_clear || !port_keep_q) begin
      keep_hold_q <= 1'b0;
    end else if (state_q == standby_pkg::ST_DEEP) begin
      keep_hold_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power, reset and pin control outputs

  assign state_deep_like = (state_q == standby_pkg::ST_DEEP) || (state_q == standby_pkg::ST_HW_STANDBY_PIN);
  assign state_hold = (state_q == standby_pkg::ST_SW_STANDBY_PIN) || (state_q == standby_pkg::ST_SW_WAKE)
                      || (state_q == standby_pkg::ST_DEEP) || (state_q == standby_pkg::ST_DEEP_WAKE);

  // outputs registered to keep them glitch free toward the power switches
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      power_q <= '0;
      ports_q <= '0;
      internal_reset <= 1'b1;
    end else begin
      power_q.cpu_stop <= state_q != standby_pkg::ST_RUN;
      power_q.periph_stop <= (state_q == standby_pkg::ST_SW_STANDBY_PIN) || state_deep_like;
      power_q.osc_stop <= (state_q == standby_pkg::ST_SW_STANDBY_PIN) || state_deep_like;
      power_q.core_power_off <= state_deep_like;
      power_q.ram4_power_off <= state_deep_like;
      power_q.ram_usb_power_off <= (state_q == standby_pkg::ST_DEEP && ram_cut_q == standby_pkg::RAM_CUT_ALL)
                                   || (state_q == standby_pkg::ST_HW_STANDBY_PIN);
      power_q.hw_standby <= state_q == standby_pkg::ST_HW_STANDBY_PIN;
      // deep wake restarts power and oscillator together under the chip reset
      internal_reset <= (state_q == standby_pkg::ST_DEEP_WAKE) || (state_q == standby_pkg::ST_PIN_RESET)
                        || (state_q == standby_pkg::ST_VMON_RESET) || (state_q == standby_pkg::ST_HW_STANDBY_PIN);
      ports_q.port_hold <= state_hold || keep_hold_q;
      ports_q.bus_hold <= state_hold;
      // clock output may be undefined one cycle as the hold drops; stop bit masks that
      ports_q.clock_out_run <= !(state_hold || keep_hold_q) && !clock_stop_q;
      ports_q.clock_out_high <= clock_stop_q;
    end
  end

  assign power = power_q;
  assign ports = ports_q;
  assign irq_handling_start = irq_start_q;
  assign reset_exception_start = rst_exc_q;

  ////////////////////////////////////////////////////////////////////////////
  // register port

  assign do_write = wr && !sys_clear;

  // configuration registers; the deep internal reset leaves them alone, pin reset clears
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      standby_sel_q <= 1'b0;
      clock_stop_q <= 1'b0;
      standby_wait_q <= standby_pkg::STANDBY_WAIT_RESET;
      deep_sel_q <= 1'b0;
      port_keep_q <= 1'b0;
      ram_cut_q <= 3'h0;
      wake_enable_q <= 4'h0;
      wake_edge_q <= 5'h00;
      deep_wait_q <= standby_pkg::DEEP_WAIT_RESET;
    end else if (sys_clear) begin
      standby_sel_q <= 1'b0;
      clock_stop_q <= 1'b0;
      standby_wait_q <= standby_pkg::STANDBY_WAIT_RESET;
      deep_sel_q <= 1'b0;
      port_keep_q <= 1'b0;
      ram_cut_q <= 3'h0;
      wake_enable_q <= 4'h0;
      wake_edge_q <= 5'h00;
      deep_wait_q <= standby_pkg::DEEP_WAIT_RESET;
    end else if (do_write) begin
      case (addr)
        standby_pkg::ADDR_STANDBY_CTRL: begin
          standby_sel_q <= wdata[standby_pkg::STANDBY_SEL_BIT];
          clock_stop_q <= wdata[standby_pkg::CLOCK_STOP_BIT];
          standby_wait_q <= wdata[4:0];
        end
        standby_pkg::ADDR_DEEP_CTRL: begin
          deep_sel_q <= wdata[standby_pkg::DEEP_SEL_BIT];
          port_keep_q <= wdata[standby_pkg::PORT_KEEP_BIT];
          ram_cut_q <= wdata[2:0];
        end
        standby_pkg::ADDR_WAKE_ENABLE: begin
          wake_enable_q <= wdata[3:0];
        end
        standby_pkg::ADDR_WAKE_EDGE: begin
          wake_edge_q <= wdata[4:0];
        end
        standby_pkg::ADDR_DEEP_WAIT: begin
          deep_wait_q <= wdata[5:0];
        end
        default: begin
        end
      endcase
    end
  end

  // clears apply only to bits read as one, and a new event beats a clear
  assign flag_clr = (do_write && addr == standby_pkg::ADDR_WAKE_FLAG) ? (flags_read_q & ~wdata[6:0]) : 7'h00;

  // sticky wake flags
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      flags_q <= 7'h00;
      flags_read_q <= 7'h00;
    end else if (sys_clear) begin
      flags_q <= 7'h00;
      flags_read_q <= 7'h00;
    end else begin
      flags_q <= (flags_q & ~flag_clr) | flag_set;
      if (rd && addr == standby_pkg::ADDR_WAKE_FLAG) begin
        flags_read_q <= flags_read_q | flags_q;
      end else begin
        flags_read_q <= flags_read_q & ~flag_clr;
      end
    end
  end

  // deep reset source flag, set on a wake-flag exit, same read-then-clear scheme
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      deep_rst_src_q <= 1'b0;
      deep_rst_read_q <= 1'b0;
    end else if (sys_clear) begin
      deep_rst_src_q <= 1'b0;
      deep_rst_read_q <= 1'b0;
    end else if (state_q == standby_pkg::ST_DEEP && state_d == standby_pkg::ST_DEEP_WAKE) begin
      deep_rst_src_q <= 1'b1;
    end else if (do_write && addr == standby_pkg::ADDR_RESET_STATUS && deep_rst_read_q
                 && !wdata[standby_pkg::DEEP_RESET_SRC_BIT]) begin
      deep_rst_src_q <= 1'b0;
      deep_rst_read_q <= 1'b0;
    end else if (rd && addr == standby_pkg::ADDR_RESET_STATUS && deep_rst_src_q) begin
      deep_rst_read_q <= 1'b1;
    end
  end

  // read data stands in the cycle after the strobe only
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= 8'h00;
    end else if (rd) begin
      case (addr)
        standby_pkg::ADDR_STANDBY_CTRL: rdata_q <= {standby_sel_q, clock_stop_q, 1'b0, standby_wait_q};
        standby_pkg::ADDR_DEEP_CTRL: rdata_q <= {deep_sel_q, port_keep_q, 3'h0, ram_cut_q};
        standby_pkg::ADDR_WAKE_ENABLE: rdata_q <= {4'h0, wake_enable_q};
        standby_pkg::ADDR_WAKE_EDGE: rdata_q <= {3'h0, wake_edge_q};
        standby_pkg::ADDR_WAKE_FLAG: rdata_q <= {1'b0, flags_q};
        standby_pkg::ADDR_DEEP_WAIT: rdata_q <= {2'h0, deep_wait_q};
        standby_pkg::ADDR_RESET_STATUS: rdata_q <= {deep_rst_src_q, 7'h00};
        standby_pkg::ADDR_STATE: rdata_q <= {keep_hold_q, pin_level[4], 3'h0, state_q};
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign rdata = rdata_q;

endmodule : deep_standby_controller

// >>> testbench/standby_props.sv
// port-level assertions for the deep standby controller
`timescale 1ns/1ps
module standby_props (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic standby_pin_b,
  input wire standby_pkg::power_ctrl_s power,
  input wire standby_pkg::port_ctrl_s ports,
  input wire logic internal_reset,
  input wire logic irq_handling_start,
  input wire logic reset_exception_start
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////////////
  // read data may only stand in the cycle after a read strobe
  rdata_idle_a: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data seen outside a read cycle");
  irq_pulse_a: assert property (irq_handling_start |=> !irq_handling_start)
    else $error("interrupt start longer than one cycle");
  reset_exit_a: assert property (reset_exception_start |-> $past(internal_reset) && !internal_reset)
    else $error("reset handling started without a released internal reset");
  deep_entry_a: assert property ($rose(power.core_power_off) |-> $past(power.cpu_stop) || power.hw_standby)
    else $error("deep standby entered without passing software standby");
  deep_power_a: assert property (power.core_power_off |->
    power.cpu_stop && power.periph_stop && power.osc_stop && power.ram4_power_off)
    else $error("deep standby left a domain running");
  ram_cut_a: assert property (power.ram_usb_power_off |-> power.core_power_off)
    else $error("ram power cut outside deep standby");
  deep_hold_a: assert property (power.core_power_off && !power.hw_standby |-> ports.port_hold)
    else $error("port pins not held in deep standby");
  wake_reset_a: assert property ($fell(power.core_power_off) |-> internal_reset || power.hw_standby)
    else $error("power restored without internal reset");
  hw_standby_a: assert property (!standby_pin_b [*4] |-> ##[0:2] power.hw_standby)
    else $error("standby pin low did not reach hardware standby");
  clock_stop_a: assert property (ports.clock_out_high |-> !ports.clock_out_run)
    else $error("bus clock runs while held high");
endmodule : standby_props

bind deep_standby_controller standby_props props (.clock(clock), .rst_b(rst_b), .rd(rd), .rdata(rdata),
  .standby_pin_b(standby_pin_b), .power(power), .ports(ports), .internal_reset(internal_reset),
  .irq_handling_start(irq_handling_start), .reset_exception_start(reset_exception_start));

// >>> testbench/pin_model.sv
// far-side pin model: wake pins, reset pin and standby pin
`timescale 1ns/1ps
module pin_model (
  input wire logic clock,
  output logic nmi_pin,
  output logic [3:0] irq_pins,
  output logic reset_pin_b,
  output logic standby_pin_b,
  output logic vmon_irq,
  output logic vmon_reset,
  output logic usb_irq
);
  // pins idle at their released levels; the monitor reset stays quiet
  initial begin
    {nmi_pin, irq_pins, vmon_irq, vmon_reset, usb_irq} = '0;
    {reset_pin_b, standby_pin_b} = 2'b11;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // levels change just after an edge and then stand until the next call
  task automatic set_nmi(input logic v);
    @(posedge clock);
    nmi_pin <= v;
  endtask : set_nmi
  task automatic set_irq(input logic [3:0] v);
    @(posedge clock);
    irq_pins <= v;
  endtask : set_irq
  task automatic set_standby(input logic v);
    @(posedge clock);
    standby_pin_b <= v;
  endtask : set_standby
  // both interrupt lines pulse long enough to pass the synchronisers
  task automatic pulse_irqs;
    @(posedge clock);
    {vmon_irq, usb_irq} <= 2'b11;
    repeat (3) @(posedge clock);
    {vmon_irq, usb_irq} <= 2'b00;
  endtask : pulse_irqs
  // reset held low for n cycles, standing in for oscillator settling
  task automatic hold_reset(input int n);
    @(posedge clock);
    reset_pin_b <= 1'b0;
    repeat (n) @(posedge clock);
    reset_pin_b <= 1'b1;
  endtask : hold_reset
  // voltage monitor reset held high for n cycles, standing in for a supply dip
  task automatic hold_vmon(input int n);
    @(posedge clock);
    vmon_reset <= 1'b1;
    repeat (n) @(posedge clock);
    vmon_reset <= 1'b0;
  endtask : hold_vmon
endmodule : pin_model

// >>> testbench/tb_top.sv
// self-checking bench for the deep standby controller
`timescale 1ns/1ps
module tb_top;
  logic clock, rst_b, wr, rd, sleep_req, nmi_pin, reset_pin_b, standby_pin_b, vmon_irq, vmon_reset, usb_irq;
  logic internal_reset, irq_start, rst_start;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, d;
  logic [3:0] irq_pins;
  standby_pkg::power_ctrl_s power;
  standby_pkg::port_ctrl_s ports;
  int fails = 0, checks_done = 0, n, base;
  int cyc[6:15] = '{512, 1024, 2048, 4096, 16384, 32768, 65536, 131072, 262144, 524288};

  // standby wait table shortened by 256 to keep the run brief
  deep_standby_controller #(.wait_shift(8)) dut (.clock(clock), .rst_b(rst_b), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .sleep_req(sleep_req), .nmi_pin(nmi_pin), .wake_interrupt_pins(irq_pins),
    .reset_pin_b(reset_pin_b), .standby_pin_b(standby_pin_b), .voltage_monitor_irq(vmon_irq),
    .voltage_monitor_reset(vmon_reset), .usb_suspend_resume_irq(usb_irq), .power(power), .ports(ports),
    .internal_reset(internal_reset), .irq_handling_start(irq_start), .reset_exception_start(rst_start));
  pin_model p (.clock(clock), .nmi_pin(nmi_pin), .irq_pins(irq_pins), .reset_pin_b(reset_pin_b),
    .standby_pin_b(standby_pin_b), .vmon_irq(vmon_irq), .vmon_reset(vmon_reset), .usb_irq(usb_irq));

  // 20 MHz clock
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : check
  // bus cycles start just after an edge; read data is taken at the second edge
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
    {addr, wdata, wr} <= {a, v, 1'b1};
    @(posedge clock);
    wr <= 1'b0;
    @(posedge clock);
  endtask : wr_reg
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] r);
    {addr, rd} <= {a, 1'b1};
    @(posedge clock);
    rd <= 1'b0;
    @(posedge clock);
    r = rdata;
  endtask : rd_reg
  task automatic rdchk(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] r;
    rd_reg(a, r);
    check(r, e);
  endtask : rdchk
  // a flag clears only when zero is written after it was read as one
  task automatic clear(input logic [2:0] a);
    logic [7:0] r;
    rd_reg(a, r);
    wr_reg(a, 8'h00);
  endtask : clear
  task automatic sleep;
    sleep_req <= 1'b1;
    @(posedge clock);
    sleep_req <= 1'b0;
    repeat (4) @(posedge clock);
  endtask : sleep
  // bounded wait: 0 interrupt start, 1 reset handling start, 2 internal reset
  task automatic wait_sig(input int w, output int k);
    k = 0;
    while (k < 3000 && (w == 0 ? irq_start : w == 1 ? rst_start : internal_reset) !== 1'b1) begin
      @(posedge clock);
      k++;
    end
    if (k == 3000) fails++;
  endtask : wait_sig
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test
  ////////////////////////////////////////////////////////////////////////////////
  // watchdog well beyond the roughly 5000 cycles the sequence needs
  initial begin
    repeat (30000) @(posedge clock);
    fails++;
    finish_test();
  end
  // main sequence
  initial begin
    {rst_b, wr, rd, sleep_req, addr, wdata} = '0;
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    rdchk(3'h0, 8'h0F);
    rdchk(3'h5, 8'h3F);
    wr_reg(3'h7, 8'hFF);
    rdchk(3'h7, 8'h00);
    p.set_irq(4'hF);
    p.pulse_irqs();
    repeat (6) @(posedge clock);
    rdchk(3'h4, 8'h60);
    clear(3'h4);
    rdchk(3'h4, 8'h00);
    // standby wait codes 06 to 0F; fixed overhead cancels against code 06
    wr_reg(3'h3, 8'h10);
    for (int c = 6; c <= 15; c++) begin
      wr_reg(3'h0, 8'h80 | 8'(c));
      sleep();
      check(power, 7'h70);
      p.set_nmi(1'b1);
      wait_sig(0, n);
      if (c == 6) base = n;
      check(n - base, (cyc[c] - cyc[6]) >> 8);
      p.set_nmi(1'b0);
    end
    // deep standby with all ram cut, keep bit clear, shortest legal deep wait
    clear(3'h4);
    wr_reg(3'h2, 8'h01);
    wr_reg(3'h3, 8'h00);
    wr_reg(3'h5, 8'h01);
    wr_reg(3'h1, 8'h87);
    sleep();
    check(power, 7'h7E);
    check(ports.port_hold, 1'b1);
    p.set_irq(4'hD);
    repeat (8) @(posedge clock);
    check(power.core_power_off, 1'b1);
    p.set_irq(4'hC);
    wait_sig(2, n);
    n = 0;
    while (internal_reset === 1'b1 && n < 400) begin
      @(posedge clock);
      n++;
    end
    check(n, 256);
    wait_sig(1, n);
    rdchk(3'h6, 8'h80);
    rdchk(3'h4, 8'h01);
    check(ports[3:2], 2'b00);
    // keep bit set, then the clean clock restart order
    clear(3'h4);
    clear(3'h6);
    p.set_irq(4'hF);
    wr_reg(3'h2, 8'h01);
    wr_reg(3'h5, 8'h01);
    wr_reg(3'h1, 8'hC0);
    wr_reg(3'h0, 8'h80);
    sleep();
    p.set_irq(4'hE);
    wait_sig(2, n);
    wait_sig(1, n);
    repeat (2) @(posedge clock);
    check(ports.port_hold, 1'b1);
    rd_reg(3'h1, d);
    check(d[6], 1'b1);
    wr_reg(3'h0, 8'h40);
    wr_reg(3'h1, 8'h00);
    repeat (2) @(posedge clock);
    check(ports, 4'h1);
    wr_reg(3'h0, 8'h00);
    repeat (2) @(posedge clock);
    check(ports, 4'h2);
    // voltage monitor reset: deep wait of 256 plus sync, reload, state and pulse cycles
    p.hold_vmon(20);
    check(internal_reset, 1'b1);
    wait_sig(1, n);
    check(n, 256 + 4);
    // reset pin brings the standby control register back to its reset value
    wr_reg(3'h0, 8'h9F);
    p.hold_reset(40);
    check(internal_reset, 1'b1);
    wait_sig(1, n);
    rdchk(3'h0, 8'h0F);
    p.set_standby(1'b0);
    repeat (6) @(posedge clock);
    check(power.hw_standby, 1'b1);
    finish_test();
  end
endmodule : tb_top
